// ---- verilog/pmw_consts.vh ----
// Purpose: constants for the power mode and wakeup controller
// Assumes: 100 MHz clk_in, AHB-Lite word registers
// Notes:   included by pmw_ctrl.v only
`ifndef PMW_CONSTS_VH
`define PMW_CONSTS_VH

// register byte addresses
`define PMW_ADDR_CTRL    8'h00
`define PMW_ADDR_STATUS  8'h04
`define PMW_ADDR_WKSRC   8'h08
`define PMW_ADDR_IOCFG   8'h0C
`define PMW_ADDR_BACKUP  8'h10

// mode request codes in CTRL[1:0]
`define PMW_REQ_NONE     2'h0
`define PMW_REQ_SLEEP    2'h1
`define PMW_REQ_STOP     2'h2
`define PMW_REQ_STANDBY  2'h3

// CTRL field positions
`define PMW_CTRL_REQ_LO  0
`define PMW_CTRL_REQ_HI  1
`define PMW_CTRL_TRX_OFF 2
`define PMW_CTRL_CLK_LO  4
`define PMW_CTRL_CLK_HI  5

// core clock selects: 8, 16, 32, 64 MHz
`define PMW_CLK_8MHZ     2'h0
`define PMW_CLK_64MHZ    2'h3

// clk_in edges after reset release before the boot select is latched
`define PMW_BOOT_SETTLE  2'h3

// wakeup latencies in ns and derived 100 MHz cycle counts (round down)
`define PMW_CLK_PERIOD_NS 10
`define PMW_SLEEP_WAKE_NS 1800
`define PMW_STOP_WAKE_NS  5400
`define PMW_STBY_WAKE_NS  50000
`define PMW_SLEEP_WAKE_CYC (`PMW_SLEEP_WAKE_NS / `PMW_CLK_PERIOD_NS)
`define PMW_STOP_WAKE_CYC  (`PMW_STOP_WAKE_NS / `PMW_CLK_PERIOD_NS)
`define PMW_STBY_WAKE_CYC  (`PMW_STBY_WAKE_NS / `PMW_CLK_PERIOD_NS)

// AHB codes
`define PMW_HTRANS_NONSEQ 2'h2
`define PMW_HSIZE_WORD    3'h2

`endif

// ---- verilog/pmw_ctrl.v ----
// Purpose: power mode sequencer with clock gating, io freeze and wakeup timing
// Assumes: AHB-Lite single word transfers, one clock, pins synchronised here
// Notes:   standby exit is signalled as a restart pulse to the reset logic
//          backup word and boot choice survive standby; only rst_b_in clears them
//          wakeup counts are in clk_in cycles at 100 MHz, rounded down
`timescale 1ns/1ns
`include "pmw_consts.vh"

module pmw_ctrl #(
    parameter NIO      = 16,
    parameter NPER     = 8,
    parameter STBY_CYC = `PMW_STBY_WAKE_CYC
) (
    // clock and reset
    input  wire            clk_in,
    input  wire            rst_b_in,
    // ahb-lite slave
    input  wire            hsel_in,
    input  wire [7:0]      haddr_in,
    input  wire [1:0]      htrans_in,
    input  wire            hwrite_in,
    input  wire [2:0]      hsize_in,
    input  wire [31:0]     hwdata_in,
    input  wire            hready_in,
    output reg  [31:0]     hrdata_out,
    output wire            hreadyout_out,
    output wire            hresp_out,
    // wakeup and boot pins
    input  wire            irq_any_in,
    input  wire            rtc_irq_in,
    input  wire            ext_irq_in,
    input  wire            wakeup_pin_in,
    input  wire            boot_loader_select_in,
    // power and clock controls
    output reg             core_clk_en_out,
    output reg  [NPER-1:0] periph_clk_en_out,
    output reg             trx_power_out,
    output reg  [1:0]      core_clk_sel_out,
    output reg             ctx_lost_out,
    output reg             restart_out,
    output reg             boot_loader_out,
    // io control
    input  wire [NIO-1:0]  io_cfg_live_in,
    output reg  [NIO-1:0]  io_cfg_out,
    output reg             io_analog_out,
    output reg  [1:0]      mode_out
);

    // one-hot sequencer states; run is also where every reset lands
    localparam [3:0] ST_RUN   = 4'h1;
    localparam [3:0] ST_SLEEP = 4'h2;
    localparam [3:0] ST_STOP  = 4'h4;
    localparam [3:0] ST_STBY  = 4'h8;

    // sequencer and software-visible register state
    reg  [3:0]      state_q;
    reg  [15:0]     wake_cnt_q;
    reg             waking_q;
    reg  [1:0]      req_q;
    reg             trx_off_q;
    reg  [1:0]      clk_sel_q;
    reg  [NPER:0]   wksrc_q;
    reg  [31:0]     backup_q;
    reg  [NIO-1:0]  io_frz_q;
    // pin synchroniser stages, oldest in the top bit
    reg  [2:0]      irq_s_q;
    reg  [2:0]      rtc_s_q;
    reg  [2:0]      ext_s_q;
    reg  [2:0]      wkp_s_q;
    reg  [2:0]      boot_loader_select_s_q;
    // boot strap capture
    reg             boot_done_q;
    reg  [1:0]      boot_age_q;
    // data phase of the bus transfer
    reg             dph_q;
    reg             dwr_q;
    reg  [7:0]      daddr_q;

    // a pin counts as high only once the second and third stage are both high
    wire irq_ok = irq_s_q[1] & irq_s_q[2];
    wire rtc_ok = rtc_s_q[1] & rtc_s_q[2];
    wire ext_ok = ext_s_q[1] & ext_s_q[2];
    wire wkp_ok = wkp_s_q[1] & wkp_s_q[2];
    wire boot_loader_select_ok = boot_loader_select_s_q[1] & boot_loader_select_s_q[2];

    // latency counts as 32-bit words; only the low 16 bits feed the counter,
    // so a standby count above 65535 cycles would need a wider counter
    wire [31:0] sleep_cyc_w = `PMW_SLEEP_WAKE_CYC;
    wire [31:0] stop_cyc_w  = `PMW_STOP_WAKE_CYC;
    wire [31:0] stby_cyc_w  = STBY_CYC;

    // bus slave is always ready and always answers okay
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    // only whole-word single transfers are taken; other sizes are ignored
    wire take = hsel_in & hready_in & (htrans_in == `PMW_HTRANS_NONSEQ) &
                (hsize_in == `PMW_HSIZE_WORD);

    // pin synchronisers, three stages each
    // the first stage may settle late; logic reads stages two and three only
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_s_q  <= 3'h0;
            rtc_s_q  <= 3'h0;
            ext_s_q  <= 3'h0;
            wkp_s_q  <= 3'h0;
            boot_loader_select_s_q <= 3'h0;
        end else begin
            irq_s_q  <= {irq_s_q[1:0], irq_any_in};
            rtc_s_q  <= {rtc_s_q[1:0], rtc_irq_in};
            ext_s_q  <= {ext_s_q[1:0], ext_irq_in};
            wkp_s_q  <= {wkp_s_q[1:0], wakeup_pin_in};
            boot_loader_select_s_q <= {boot_loader_select_s_q[1:0], boot_loader_select_in};
        end
    end

    // boot strap: taken once the synchroniser has refilled after release,
    // so a level held high through reset is not mistaken for a low one
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            boot_age_q      <= 2'h0;
            boot_done_q     <= 1'b0;
            boot_loader_out <= 1'b0;
        end else if (!boot_done_q) begin
            if (boot_age_q == `PMW_BOOT_SETTLE) begin
                boot_done_q     <= 1'b1;
                boot_loader_out <= boot_loader_select_ok;
            end else begin
                boot_age_q <= boot_age_q + 2'h1;
            end
        end
    end

    // address phase capture
    // a stalled bus holds the previous phase, so capture only on hready
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dph_q   <= 1'b0;
            dwr_q   <= 1'b0;
            daddr_q <= 8'h00;
        end else if (hready_in) begin
            dph_q   <= take;
            dwr_q   <= hwrite_in;
            daddr_q <= haddr_in;
        end
    end

    // write strobe of the data phase; hwdata stands only in this cycle
    wire wr = dph_q & dwr_q;
    wire [1:0] wr_clk = hwdata_in[`PMW_CTRL_CLK_HI:`PMW_CTRL_CLK_LO];

    // register writes; mode request is a one-shot consumed by the sequencer
    // clock select and transceiver switch reach the outputs a cycle later
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            req_q     <= `PMW_REQ_NONE;
            trx_off_q <= 1'b0;
            clk_sel_q <= `PMW_CLK_8MHZ;
            wksrc_q   <= {(NPER+1){1'b0}};
        end else begin
            if (state_q != ST_RUN)
                req_q <= `PMW_REQ_NONE;
            if (wr && daddr_q == `PMW_ADDR_CTRL) begin
                // a request made outside run is dropped, so a write landing as a
                // wakeup completes cannot send the block straight back down
                if (state_q == ST_RUN)
                    req_q <= hwdata_in[`PMW_CTRL_REQ_HI:`PMW_CTRL_REQ_LO];
                else
                    req_q <= `PMW_REQ_NONE;
                trx_off_q <= hwdata_in[`PMW_CTRL_TRX_OFF];
                // select above 64 MHz cannot exist; the top code is the cap
                clk_sel_q <= (wr_clk > `PMW_CLK_64MHZ) ? `PMW_CLK_64MHZ : wr_clk;
            end
            if (wr && daddr_q == `PMW_ADDR_WKSRC)
                wksrc_q <= hwdata_in[NPER:0];
        end
    end

    // backup word: never cleared by mode changes, only by true reset
    // it stays readable and writable in sleep, stop and standby alike
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            backup_q <= 32'h0;
        else if (wr && daddr_q == `PMW_ADDR_BACKUP)
            backup_q <= hwdata_in;
    end

    // mode sequencer and wakeup latency counter
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q    <= ST_RUN;
            wake_cnt_q <= 16'h0;
            waking_q   <= 1'b0;
            restart_out <= 1'b0;
            ctx_lost_out <= 1'b0;
        end else begin
            restart_out <= 1'b0;
            // software clears the flag; a standby entry in the same cycle is
            // assigned below and wins, so a loss of context is never missed
            if (wr && daddr_q == `PMW_ADDR_STATUS)
                ctx_lost_out <= 1'b0;
            // the old mode's outputs stand through the count; run returns only
            // when it expires, which is what sets the wakeup latency
            if (waking_q) begin
                if (wake_cnt_q == 16'h1) begin
                    waking_q <= 1'b0;
                    if (state_q == ST_STBY)
                        restart_out <= 1'b1;
                    state_q <= ST_RUN;
                end
                wake_cnt_q <= wake_cnt_q - 16'h1;
            end else begin
                case (state_q)
                    // only an explicit write of a mode code leaves run
                    ST_RUN: begin
                        if (req_q == `PMW_REQ_SLEEP)
                            state_q <= ST_SLEEP;
                        else if (req_q == `PMW_REQ_STOP)
                            state_q <= ST_STOP;
                        else if (req_q == `PMW_REQ_STANDBY) begin
                            state_q <= ST_STBY;
                            ctx_lost_out <= 1'b1;
                        end
                    end
                    // sleep wakes on any interrupt request
                    ST_SLEEP: if (irq_ok) begin
                        waking_q   <= 1'b1;
                        wake_cnt_q <= sleep_cyc_w[15:0];
                    end
                    // stop wakes on rtc or ext irq, never on a peripheral irq
                    ST_STOP: if (rtc_ok || ext_ok) begin
                        waking_q   <= 1'b1;
                        wake_cnt_q <= stop_cyc_w[15:0];
                    end
                    // standby ignores ext irq; only rtc and the wakeup pin count
                    ST_STBY: if (rtc_ok || wkp_ok) begin
                        waking_q   <= 1'b1;
                        wake_cnt_q <= stby_cyc_w[15:0];
                    end
                    default: state_q <= ST_RUN;
                endcase
            end
        end
    end

    // io freeze: snapshot live config on the run cycle, held elsewhere
    // the last run cycle's config is what stop and sleep keep showing
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            io_frz_q <= {NIO{1'b0}};
        else if (state_q == ST_RUN)
            io_frz_q <= io_cfg_live_in;
    end

    // clock, power and io outputs per mode
    // registered, so each mode shows one cycle after the state changes
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            core_clk_en_out   <= 1'b1;
            periph_clk_en_out <= {NPER{1'b1}};
            trx_power_out     <= 1'b1;
            core_clk_sel_out  <= `PMW_CLK_8MHZ;
            io_cfg_out        <= {NIO{1'b0}};
            io_analog_out     <= 1'b0;
            mode_out          <= 2'h0;
        end else begin
            core_clk_sel_out <= clk_sel_q;
            case (state_q)
                ST_RUN: begin
                    core_clk_en_out   <= 1'b1;
                    periph_clk_en_out <= {NPER{1'b1}};
                    trx_power_out     <= ~trx_off_q;
                    io_cfg_out        <= io_cfg_live_in;
                    io_analog_out     <= 1'b0;
                    mode_out          <= 2'h0;
                end
                // sleep: only peripherals picked as wakeup sources keep a clock
                ST_SLEEP: begin
                    core_clk_en_out   <= 1'b0;
                    periph_clk_en_out <= wksrc_q[NPER-1:0];
                    trx_power_out     <= wksrc_q[NPER] & ~trx_off_q;
                    io_cfg_out        <= io_frz_q;
                    io_analog_out     <= 1'b0;
                    mode_out          <= 2'h1;
                end
                // stop: every peripheral clock off whatever the wakeup mask says
                ST_STOP: begin
                    core_clk_en_out   <= 1'b0;
                    periph_clk_en_out <= {NPER{1'b0}};
                    trx_power_out     <= wksrc_q[NPER] & ~trx_off_q;
                    io_cfg_out        <= io_frz_q;
                    io_analog_out     <= 1'b0;
                    mode_out          <= 2'h2;
                end
                // standby: io to analog input, the far side holds its own levels
                default: begin
                    core_clk_en_out   <= 1'b0;
                    periph_clk_en_out <= {NPER{1'b0}};
                    trx_power_out     <= 1'b0;
                    io_cfg_out        <= {NIO{1'b0}};
                    io_analog_out     <= 1'b1;
                    mode_out          <= 2'h3;
                end
            endcase
        end
    end

    // read data in the data phase
    // outside a read data phase the bus sees zero, never a stale word
    always @* begin
        hrdata_out = 32'h0;
        if (dph_q && !dwr_q) begin
            case (daddr_q)
                `PMW_ADDR_CTRL:   hrdata_out = {26'h0, clk_sel_q, 1'b0, trx_off_q, req_q};
                `PMW_ADDR_STATUS: hrdata_out = {24'h0, ctx_lost_out, boot_loader_out,
                                                waking_q, 1'b0, state_q};
                `PMW_ADDR_WKSRC:  hrdata_out = {{(31-NPER){1'b0}}, wksrc_q};
                `PMW_ADDR_IOCFG:  hrdata_out = {{(32-NIO){1'b0}}, io_cfg_out};
                `PMW_ADDR_BACKUP: hrdata_out = backup_q;
                default:          hrdata_out = 32'h0;
            endcase
        end
    end

endmodule

// ---- tb/pmw_pins.sv ----
// Purpose: far-side drivers of the wakeup, irq and boot select pins
// Assumes: levels change only just after a rising clock edge
// Notes:   bit 0 any irq, 1 rtc, 2 ext irq, 3 wakeup pin, 4 boot select
`timescale 1ns/1ns
module pmw_pins (
    // clock and levels asked for by the bench
    input  wire logic       clk_in,
    input  wire logic [4:0] lvl_in,
    // pin levels seen by the block
    output logic      [4:0] pin_out
);
    // all pins start low, like the pulled-down boot select
    initial pin_out = 5'h00;
    // outside keeps driving its own levels, through reset and standby alike
    always @(posedge clk_in) begin
        pin_out <= lvl_in;
    end
endmodule

// ---- tb/pmw_chk_properties.sv ----
// Purpose: port-level checks of the power mode controller
// Assumes: one clock, async active low reset
// Notes:   bound to every pmw_ctrl instance
`timescale 1ns/1ns
module pmw_chk #(
    parameter NIO  = 16,
    parameter NPER = 8
) (
    // clock, reset and wake pins
    input wire logic            clk_in,
    input wire logic            rst_b_in,
    input wire logic            irq_any_in,
    input wire logic            rtc_irq_in,
    input wire logic            ext_irq_in,
    // power, clock and io controls
    input wire logic            core_clk_en_out,
    input wire logic [NPER-1:0] periph_clk_en_out,
    input wire logic            trx_power_out,
    input wire logic [1:0]      core_clk_sel_out,
    input wire logic            boot_loader_out,
    input wire logic [NIO-1:0]  io_cfg_out,
    input wire logic            io_analog_out,
    input wire logic [1:0]      mode_out
);
    logic       stop_wk;
    logic [3:0] age_q;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // only these two may end stop
    assign stop_wk = rtc_irq_in | ext_irq_in;
    // cycles since reset release; boot select has settled well before 15
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            age_q <= 4'h0;
        else if (age_q != 4'hF)
            age_q <= age_q + 4'h1;
    end
    property p_reset_run;
        $rose(rst_b_in) |-> mode_out == 2'h0 && core_clk_sel_out == 2'h0 && core_clk_en_out;
    endproperty
    a_reset_run: assert property (p_reset_run) else $error("not run at 8 MHz");
    property p_sleep_gate;
        mode_out == 2'h1 |-> !core_clk_en_out;
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("core clocked in sleep");
    property p_stop_gate;
        mode_out == 2'h2 |-> !core_clk_en_out && periph_clk_en_out == {NPER{1'b0}};
    endproperty
    a_stop_gate: assert property (p_stop_gate) else $error("clock runs in stop");
    property p_stby;
        mode_out == 2'h3 |-> io_analog_out && !trx_power_out && periph_clk_en_out == 0;
    endproperty
    a_stby: assert property (p_stby) else $error("standby not powered down");
    property p_stop_io;
        mode_out == 2'h2 && $past(mode_out) == 2'h2 |-> $stable(io_cfg_out);
    endproperty
    a_stop_io: assert property (p_stop_io) else $error("io moved in stop");
    property p_sleep_lat;
        mode_out == 2'h1 ##1 mode_out == 2'h0 |-> $past(irq_any_in, 150);
    endproperty
    a_sleep_lat: assert property (p_sleep_lat) else $error("sleep left too soon");
    property p_stop_lat;
        mode_out == 2'h2 ##1 mode_out == 2'h0 |-> $past(stop_wk, 300);
    endproperty
    a_stop_lat: assert property (p_stop_lat) else $error("stop left too soon");
    property p_boot_hold;
        age_q == 4'hF |-> $stable(boot_loader_out);
    endproperty
    a_boot_hold: assert property (p_boot_hold) else $error("boot choice moved");
endmodule
bind pmw_ctrl pmw_chk #(.NIO(NIO), .NPER(NPER)) u_chk (.clk_in, .rst_b_in, .irq_any_in,
    .rtc_irq_in, .ext_irq_in, .core_clk_en_out, .periph_clk_en_out, .trx_power_out,
    .core_clk_sel_out, .boot_loader_out, .io_cfg_out, .io_analog_out, .mode_out);

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the power mode controller
// Assumes: zero-wait bus slave, standby wake count cut to 20
// Notes:   pin levels reach the block through the far-side model
`timescale 1ns/1ns
module tb;
    logic        clk_in = 1'b0, rst_b_in = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0, sel, mode;
    logic [7:0]  haddr = 8'h00, periph, restarts = 8'h00;
    logic [31:0] hwdata = 32'h0, hrdata, rd_q, rd;
    logic        hready, core_en, trx, ctx, restart, boot, analog, resp;
    logic [15:0] live = 16'h0000, io;
    logic [4:0]  lvl = 5'h00, pin;
    int          error_cnt = 0, comparisons = 0, n;
    always #5 clk_in = ~clk_in;
    // read data taken at the closing edge; restart pulses counted
    always @(posedge clk_in) begin
        rd_q <= hrdata;
        if (restart === 1'b1)
            restarts <= restarts + 8'h01;
    end
    pmw_pins u_pins (.clk_in(clk_in), .lvl_in(lvl), .pin_out(pin));
    pmw_ctrl #(.STBY_CYC(20)) dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .hsel_in(1'b1),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(resp), .irq_any_in(pin[0]), .rtc_irq_in(pin[1]), .ext_irq_in(pin[2]),
        .wakeup_pin_in(pin[3]), .boot_loader_select_in(pin[4]), .core_clk_en_out(core_en),
        .periph_clk_en_out(periph), .trx_power_out(trx), .core_clk_sel_out(sel),
        .ctx_lost_out(ctx), .restart_out(restart), .boot_loader_out(boot),
        .io_cfg_live_in(live), .io_cfg_out(io), .io_analog_out(analog), .mode_out(mode));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cyc(input int c);
        repeat (c) @(posedge clk_in);
        #1;
    endtask
    // one single word transfer; waits on hready at both phases
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_in);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_in); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_in); while (hready !== 1'b1);
        #1 rd = rd_q;
    endtask
    // raise pins, count cycles until run or the limit, then drop them
    task wake(input logic [4:0] l, input int lim, output int k);
        @(posedge clk_in);
        lvl <= l;
        for (k = 1; k < lim && mode !== 2'h0; k++) cyc(1);
        @(posedge clk_in);
        lvl <= 5'h00;
    endtask
    task t_run();
        cyc(1);
        chk({mode, sel, boot}, 5'h00);
        bus(1'b0, 8'h04, 32'h0);
        chk({resp, rd[3:0]}, 5'h01);
        bus(1'b1, 8'h00, 32'h34); // transceiver off, 64 MHz, no mode asked
        cyc(2);
        chk({trx, core_en, sel, mode}, 6'h1C);
        bus(1'b1, 8'h10, 32'hA5A5_5A5A);
        bus(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
    endtask
    task t_sleep();
        bus(1'b1, 8'h08, 32'h101); // peripheral 0 and transceiver wake
        bus(1'b1, 8'h00, 32'h1);
        cyc(2);
        chk({mode, core_en, trx, periph}, 12'h501);
        bus(1'b1, 8'h00, 32'h2);
        bus(1'b0, 8'h10, 32'h0);
        chk(mode, 2'h1);
        chk(rd, 32'hA5A5_5A5A);
        wake(5'h01, 400, n);
        chk(n >= 181 && n <= 192, 1'b1);
        bus(1'b0, 8'h04, 32'h0);
        chk({core_en, rd[7], rd[3:0]}, 6'h21);
    endtask
    task t_stop();
        @(posedge clk_in);
        live <= 16'h1234;
        bus(1'b1, 8'h00, 32'h2);
        cyc(2);
        @(posedge clk_in);
        live <= 16'hFFFF;
        cyc(3);
        chk({mode, core_en, periph, io}, {2'h2, 9'h000, 16'h1234});
        wake(5'h01, 600, n);
        chk(mode, 2'h2);
        wake(5'h02, 700, n);
        chk(n >= 541 && n <= 552, 1'b1);
        cyc(2);
        chk({core_en, io}, {1'b1, 16'hFFFF});
    endtask
    task t_stby();
        bus(1'b1, 8'h00, 32'h3);
        cyc(2);
        chk({mode, analog, trx, periph, ctx}, 13'h1C01);
        wake(5'h04, 60, n);
        chk(mode, 2'h3);
        wake(5'h08, 60, n);
        chk(n >= 21 && n <= 30, 1'b1);
        cyc(2);
        chk({mode, restarts}, 10'h001);
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'hA5A5_5A5A);
        bus(1'b1, 8'h04, 32'h0);
        cyc(1);
        chk(ctx, 1'b0);
    endtask
    task t_boot();
        @(posedge clk_in);
        lvl <= 5'h10;
        rst_b_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        cyc(8);
        chk({boot, mode, sel}, 5'h10);
        @(posedge clk_in);
        lvl <= 5'h00;
        cyc(10);
        bus(1'b0, 8'h04, 32'h0);
        chk({boot, rd[6]}, 2'h3);
    endtask
    task test_done();
        $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // main sequence after 3 cycles of reset
    initial begin
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_run();
        t_sleep();
        t_stop();
        t_stby();
        t_boot();
        test_done();
    end
    // watchdog: the tests need some 1500 cycles
    initial begin
        #100000;
        error_cnt++;
        test_done();
    end
endmodule
